// ### timer_wave_params.svh
// Offsets, field positions, reset values and fixed counts for the timer
// waveform and compare-output control block.
// Assumes inclusion by bare name from the design file or the bench.
`ifndef TIMER_WAVE_PARAMS_SVH
`define TIMER_WAVE_PARAMS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define TW_IDX_CTRL_A 10'h0b0
`define TW_IDX_CTRL_B 10'h0b1
`define TW_IDX_CMP_A 10'h0b3
`define TW_IDX_CMP_B 10'h0b4
`define TW_IDX_STATUS 10'h0c0
`define TW_IDX_CLEAR 10'h0c1
`define TW_IDX_ENABLE 10'h0c2
`define TW_IDX_COUNT 10'h0c3
`define TW_ADDR_W 12

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define TW_A_CMP_A_HI 7
`define TW_A_CMP_A_LO 6
`define TW_A_CMP_B_HI 5
`define TW_A_CMP_B_LO 4
`define TW_A_MODE_HI 1
`define TW_A_MODE_LO 0
`define TW_B_MODE2 3
`define TW_B_CS_HI 2
`define TW_B_CS_LO 0
`define TW_A_WRITE_MASK 8'hf3
`define TW_B_WRITE_MASK 8'h0f
`define TW_CTRL_RESET 8'h00
`define TW_ST_OVF 0
`define TW_ST_MATCH_A 1
`define TW_ST_MATCH_B 2
`define TW_EVENTS 3

// ----------------------------------------------------------------------
// Counter limits and bus answers
// ----------------------------------------------------------------------
`define TW_MAX 8'hff
`define TW_BOTTOM 8'h00
`define TW_RESP_OKAY 2'h0
`define TW_RESP_SLVERR 2'h2

`endif

// ### timer_wave_pkg.sv
// Types shared by the timer waveform and compare-output control block.
// Assumes the constants header sits in the same folder.
`default_nettype none
package timer_wave_pkg;

   // Counting behaviour selected by the three-bit waveform mode.
   typedef enum logic [2:0] {
      KIND_NORMAL = 3'b000,
      KIND_PHASE = 3'b001,
      KIND_MATCH_CLR = 3'b010,
      KIND_FAST = 3'b011,
      KIND_RSVD = 3'b100
   } wave_kind_t;

   // Moment at which the active compare values follow the buffers.
   typedef enum logic [1:0] {
      UPD_NOW = 2'b00,
      UPD_TOP = 2'b01,
      UPD_BOTTOM = 2'b10
   } cmp_update_t;

endpackage
`default_nettype wire

// ### timer_compare_waveform_ctrl.sv
// Waveform generation and compare-output control of an 8-bit timer, with
// its counter, compare buffers, event flags and an AXI4-Lite slave.
// Assumes one clock; prescaling and pin direction live outside the block.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "timer_wave_params.svh"
`default_nettype none

// Behaviour
// - Nonzero A output mode lets channel A output take over its pin.
// - Nonzero B output mode lets channel B output take over its pin.
// - Non-PWM A modes: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Non-PWM B modes: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM A: 10 clears on match, sets at bottom; 11 reversed.
// - PWM A value 01: disconnected if mode bit 2 low, else toggles.
// - Phase PWM A: 10 clears on up match, sets on down match; 11 reversed.
// - Fast PWM B: 10 clear on match, set at bottom; 11 reversed; 01 reserved.
// - Phase PWM B: 10 clear up, set down; 11 reversed; 01 reserved.
// - Fast PWM, compare equals top, high bit set: ignore match, act at bottom.
// - Phase PWM, compare equals top, high bit set: ignore match, act at top.
// - Control A bits 3 and 2 are read-only and read zero.
// - Waveform mode combines control A bits 1..0 with control B bit 3.
// - Modes 0,1,3 top is max; modes 2,5,7 top is compare A.
// - Compare update and overflow moment both follow the waveform mode.
module timer_compare_waveform_ctrl (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic cmp_a_out_pin,
   output logic cmp_b_out_pin,
   output logic cmp_a_override,
   output logic cmp_b_override,
   output logic irq
);
   import timer_wave_pkg::*;

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   logic [7:0] ctrl_a_q;
   logic [7:0] ctrl_b_q;
   logic [7:0] cmp_a_buf_q;
   logic [7:0] cmp_b_buf_q;
   logic [7:0] cmp_a_value_q;
   logic [7:0] cmp_b_value_q;
   logic [7:0] cnt_q;
   logic dir_down_q;
   logic out_a_q;
   logic out_b_q;
   logic [`TW_EVENTS-1:0] status_q;
   logic [`TW_EVENTS-1:0] irq_en_q;
   logic aw_pend_q;
   logic w_pend_q;
   logic [11:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   logic [2:0] wave_gen_mode;
   logic [1:0] cmp_a_out_mode;
   logic [1:0] cmp_b_out_mode;
   logic wave_gen_mode_bit2;
   logic [2:0] clock_select_field;
   wave_kind_t kind;
   cmp_update_t upd;
   logic [7:0] top;
   logic running;
   logic at_top;
   logic match_a;
   logic match_b;
   logic ovf_evt;
   logic is_pwm;
   logic a_is_top;
   logic b_is_top;
   logic wr_go;
   logic [9:0] wr_idx;
   logic [9:0] rd_idx;
   logic [`TW_EVENTS-1:0] clr_bits;
   logic [`TW_EVENTS-1:0] evt_bits;

   // ----------------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------------
   // mode field assembly
   assign wave_gen_mode_bit2 = ctrl_b_q[`TW_B_MODE2];
   assign wave_gen_mode = {wave_gen_mode_bit2,
                           ctrl_a_q[`TW_A_MODE_HI:`TW_A_MODE_LO]};
   assign cmp_a_out_mode = ctrl_a_q[`TW_A_CMP_A_HI:`TW_A_CMP_A_LO];
   assign cmp_b_out_mode = ctrl_a_q[`TW_A_CMP_B_HI:`TW_A_CMP_B_LO];
   assign clock_select_field = ctrl_b_q[`TW_B_CS_HI:`TW_B_CS_LO];

   // kind and top source. Reserved modes count like normal mode so
   // that a stray setting never hangs the counter.
   always_comb begin
      case (wave_gen_mode)
         3'h0: begin
            kind = KIND_NORMAL;
            top = `TW_MAX;
         end
         3'h1: begin
            kind = KIND_PHASE;
            top = `TW_MAX;
         end
         3'h2: begin
            kind = KIND_MATCH_CLR;
            top = cmp_a_value_q;
         end
         3'h3: begin
            kind = KIND_FAST;
            top = `TW_MAX;
         end
         3'h5: begin
            kind = KIND_PHASE;
            top = cmp_a_value_q;
         end
         3'h7: begin
            kind = KIND_FAST;
            top = cmp_a_value_q;
         end
         default: begin
            kind = KIND_RSVD;
            top = `TW_MAX;
         end
      endcase
   end

   // compare update moment and overflow moment per mode.
   always_comb begin
      case (kind)
         KIND_PHASE: begin
            upd = UPD_TOP;
            ovf_evt = running && cnt_q == `TW_BOTTOM && dir_down_q;
         end
         KIND_FAST: begin
            upd = UPD_BOTTOM;
            ovf_evt = wave_gen_mode_bit2 ? at_top
                                         : (running && cnt_q == `TW_MAX);
         end
         default: begin
            upd = UPD_NOW;
            ovf_evt = running && cnt_q == `TW_MAX;
         end
      endcase
   end

   assign running = clock_select_field != 3'h0;
   assign at_top = running && cnt_q == top;
   assign match_a = running && cnt_q == cmp_a_value_q;
   assign match_b = running && cnt_q == cmp_b_value_q;
   assign is_pwm = kind == KIND_PHASE || kind == KIND_FAST;
   assign a_is_top = cmp_a_value_q == top;
   assign b_is_top = cmp_b_value_q == top;

   // ----------------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------------
   // Single slope wraps from top to bottom; dual slope turns at both ends.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= `TW_BOTTOM;
         dir_down_q <= 1'b0;
      end else if (running) begin
         if (kind != KIND_PHASE) begin
            dir_down_q <= 1'b0;
            cnt_q <= at_top ? `TW_BOTTOM : cnt_q + 8'h01;
         end else if (!dir_down_q) begin
            if (at_top) begin
               dir_down_q <= 1'b1;
               cnt_q <= (top == `TW_BOTTOM) ? `TW_BOTTOM : cnt_q - 8'h01;
            end else begin
               cnt_q <= cnt_q + 8'h01;
            end
         end else if (cnt_q == `TW_BOTTOM) begin
            dir_down_q <= 1'b0;
            cnt_q <= (top == `TW_BOTTOM) ? `TW_BOTTOM : 8'h01;
         end else begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end

   // active compare values follow the software buffers. Updating
   // only at top or bottom in PWM keeps each period glitch free.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_a_value_q <= `TW_BOTTOM;
         cmp_b_value_q <= `TW_BOTTOM;
      end else if (upd == UPD_NOW || at_top) begin
         cmp_a_value_q <= cmp_a_buf_q;
         cmp_b_value_q <= cmp_b_buf_q;
      end
   end

   // ----------------------------------------------------------------------
   // Compare output waveform
   // ----------------------------------------------------------------------
   // Next level of one compare output.  tog_ok allows the PWM toggle.
   function automatic logic chan_next(input wave_kind_t k,
                                      input logic [1:0] com,
                                      input logic tog_ok,
                                      input logic match,
                                      input logic top_hit,
                                      input logic down,
                                      input logic cmp_top,
                                      input logic cur);
      logic nxt;
      nxt = cur;
      case (k)
         KIND_FAST: begin
            if (com[1]) begin
               if (top_hit) begin
                  nxt = ~com[0];
               end else if (match && !cmp_top) begin
                  nxt = com[0];
               end
            end else if (com[0] && tog_ok && match) begin
               nxt = ~cur;
            end
         end
         KIND_PHASE: begin
            if (com[1]) begin
               if (cmp_top && top_hit) begin
                  nxt = ~com[0];
               end else if (match && !cmp_top) begin
                  nxt = down ? ~com[0] : com[0];
               end
            end else if (com[0] && tog_ok && match) begin
               nxt = ~cur;
            end
         end
         default: begin
            if (match) begin
               case (com)
                  2'b01: nxt = ~cur;
                  2'b10: nxt = 1'b0;
                  2'b11: nxt = 1'b1;
                  default: nxt = cur;
               endcase
            end
         end
      endcase
      return nxt;
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_a_q <= 1'b0;
      end else begin
         out_a_q <= chan_next(kind, cmp_a_out_mode, wave_gen_mode_bit2,
                              match_a, at_top, dir_down_q, a_is_top,
                              out_a_q);
      end
   end

   // channel B output level; no PWM toggle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_b_q <= 1'b0;
      end else begin
         out_b_q <= chan_next(kind, cmp_b_out_mode, 1'b0, match_b, at_top,
                              dir_down_q, b_is_top, out_b_q);
      end
   end

   // pin takeover. The driver itself still needs
   // the port direction bit, which lives outside this block.
   assign cmp_a_override = cmp_a_out_mode != 2'b00 &&
      !(is_pwm && cmp_a_out_mode == 2'b01 && !wave_gen_mode_bit2);
   assign cmp_b_override = cmp_b_out_mode != 2'b00 &&
      !(is_pwm && cmp_b_out_mode == 2'b01);
   assign cmp_a_out_pin = out_a_q;
   assign cmp_b_out_pin = out_b_q;

   // ----------------------------------------------------------------------
   // Event flags and interrupt
   // ----------------------------------------------------------------------
   assign evt_bits = {match_b, match_a, ovf_evt};
   assign clr_bits = (wr_go && wr_idx == `TW_IDX_CLEAR && w_strb_q[0])
                     ? w_data_q[`TW_EVENTS-1:0] : '0;

   // A flag raised in the cycle it is cleared stays set.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_q <= '0;
      end else begin
         status_q <= (status_q & ~clr_bits) | evt_bits;
      end
   end

   assign irq = |(status_q & irq_en_q);

   // ----------------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------------
   assign s_axi_awready = !aw_pend_q && !bvalid_q;
   assign s_axi_wready = !w_pend_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign wr_go = aw_pend_q && w_pend_q && !bvalid_q;
   assign wr_idx = aw_addr_q[11:2];
   assign rd_idx = s_axi_araddr[11:2];

   // Address and data may arrive in either order; both are held here.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_pend_q <= 1'b0;
         w_pend_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_pend_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_pend_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_pend_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_go) begin
            w_pend_q <= 1'b0;
         end
      end
   end

   // register writes; reserved and strobe bits are never stored.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_a_q <= `TW_CTRL_RESET;
         ctrl_b_q <= `TW_CTRL_RESET;
         cmp_a_buf_q <= `TW_BOTTOM;
         cmp_b_buf_q <= `TW_BOTTOM;
         irq_en_q <= '0;
      end else if (wr_go && w_strb_q[0]) begin
         case (wr_idx)
            `TW_IDX_CTRL_A: ctrl_a_q <= w_data_q[7:0] & `TW_A_WRITE_MASK;
            `TW_IDX_CTRL_B: ctrl_b_q <= w_data_q[7:0] & `TW_B_WRITE_MASK;
            `TW_IDX_CMP_A: cmp_a_buf_q <= w_data_q[7:0];
            `TW_IDX_CMP_B: cmp_b_buf_q <= w_data_q[7:0];
            `TW_IDX_ENABLE: irq_en_q <= w_data_q[`TW_EVENTS-1:0];
            default: ;
         endcase
      end
   end

   // Write answer one cycle after both halves are held.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= `TW_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         case (wr_idx)
            `TW_IDX_CTRL_A, `TW_IDX_CTRL_B, `TW_IDX_CMP_A, `TW_IDX_CMP_B,
            `TW_IDX_CLEAR, `TW_IDX_ENABLE: bresp_q <= `TW_RESP_OKAY;
            default: bresp_q <= `TW_RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Read answer one cycle after the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= `TW_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rresp_q <= `TW_RESP_OKAY;
         case (rd_idx)
            `TW_IDX_CTRL_A: rdata_q <= {24'h000000, ctrl_a_q};
            `TW_IDX_CTRL_B: rdata_q <= {24'h000000, ctrl_b_q};
            `TW_IDX_CMP_A: rdata_q <= {24'h000000, cmp_a_buf_q};
            `TW_IDX_CMP_B: rdata_q <= {24'h000000, cmp_b_buf_q};
            `TW_IDX_STATUS: rdata_q <= {29'h0, status_q};
            `TW_IDX_ENABLE: rdata_q <= {29'h0, irq_en_q};
            `TW_IDX_COUNT: rdata_q <= {24'h000000, cnt_q};
            `TW_IDX_CLEAR: rdata_q <= 32'h00000000;
            default: begin
               rdata_q <= 32'h00000000;
               rresp_q <= `TW_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_rsvd_zero: assert property (ctrl_a_q[3:2] == 2'b00)
      else $error("reserved control bits not zero");
   a_take_pin_a: assert property (
      cmp_a_out_mode[1] |-> cmp_a_override)
      else $error("channel A did not take the pin");
   a_take_pin_b: assert property (
      cmp_b_out_mode[1] |-> cmp_b_override)
      else $error("channel B did not take the pin");
   a_nonpwm_toggle: assert property (
      !is_pwm && cmp_a_out_mode == 2'b01 && match_a
      |=> out_a_q != $past(out_a_q))
      else $error("channel A did not toggle on match");
   a_nonpwm_clear: assert property (
      !is_pwm && cmp_b_out_mode == 2'b10 && match_b |=> !out_b_q)
      else $error("channel B did not clear on match");
   a_fast_bottom: assert property (
      kind == KIND_FAST && cmp_a_out_mode == 2'b10 && at_top
      |=> out_a_q && cnt_q == `TW_BOTTOM)
      else $error("channel A not set at bottom");
   a_pwm_disc: assert property (
      is_pwm && cmp_a_out_mode == 2'b01 && !wave_gen_mode_bit2
      |-> !cmp_a_override)
      else $error("channel A not disconnected");
   a_phase_down: assert property (
      kind == KIND_PHASE && cmp_a_out_mode == 2'b10 && match_a &&
      dir_down_q && !a_is_top |=> out_a_q)
      else $error("channel A not set on down match");
   a_fast_b_inv: assert property (
      kind == KIND_FAST && cmp_b_out_mode == 2'b11 && match_b &&
      !b_is_top && !at_top |=> out_b_q)
      else $error("channel B not set on match");
   a_phase_b_up: assert property (
      kind == KIND_PHASE && cmp_b_out_mode == 2'b10 && match_b &&
      !dir_down_q && !b_is_top |=> !out_b_q)
      else $error("channel B not cleared on up match");
   a_fast_ignore: assert property (
      kind == KIND_FAST && cmp_a_out_mode[1] && a_is_top && at_top
      |=> out_a_q == !$past(cmp_a_out_mode[0]))
      else $error("fast top case wrong on channel A");
   a_phase_top: assert property (
      kind == KIND_PHASE && cmp_a_out_mode[1] && a_is_top && at_top
      |=> out_a_q == !$past(cmp_a_out_mode[0]))
      else $error("phase top case wrong on channel A");
   a_ctc_wrap: assert property (
      wave_gen_mode == 3'h2 && match_a |=> cnt_q == `TW_BOTTOM)
      else $error("clear-on-match mode did not wrap");
   a_ovf_phase: assert property (
      kind == KIND_PHASE && running && cnt_q == `TW_BOTTOM && dir_down_q
      |=> status_q[`TW_ST_OVF])
      else $error("overflow flag missed at bottom");
   a_rsvd_b: assert property (
      is_pwm && cmp_b_out_mode == 2'b01 |-> !cmp_b_override)
      else $error("reserved channel B setting took the pin");

   c_fast_wrap: cover property (kind == KIND_FAST && at_top ##1
                                cnt_q == `TW_BOTTOM);
   c_phase_turn: cover property (kind == KIND_PHASE && at_top ##1
                                 dir_down_q);
   c_irq: cover property (!irq ##1 irq);

endmodule
`default_nettype wire

// ### timer_compare_waveform_ctrl_bench.sv
// Self-checking bench for the timer waveform and compare-output block.
// Assumes the design, its package and the constants header come first.
`timescale 1ns/1ps
`include "timer_wave_params.svh"
`default_nettype none
module timer_compare_waveform_ctrl_bench;
   localparam logic [9:0] i_ca = `TW_IDX_CTRL_A, i_cb = `TW_IDX_CTRL_B;
   localparam logic [9:0] i_pa = `TW_IDX_CMP_A, i_pb = `TW_IDX_CMP_B;
   localparam logic [9:0] i_st = `TW_IDX_STATUS, i_cl = `TW_IDX_CLEAR;
   localparam logic [9:0] i_en = `TW_IDX_ENABLE;
   localparam logic [1:0] ok = `TW_RESP_OKAY;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, cmp_a_out_pin, cmp_b_out_pin, irq;
   logic cmp_a_override, cmp_b_override, ta, tb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int n_fail = 0, check_count = 0, ha, hb;

   timer_compare_waveform_ctrl i_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .cmp_a_out_pin(cmp_a_out_pin), .cmp_b_out_pin(cmp_b_out_pin),
      .cmp_a_override(cmp_a_override), .cmp_b_override(cmp_b_override),
      .irq(irq));

   // Free-running 50 MHz clock.
   always #10 aclk = ~aclk;

   // --------------------------------------------------------------------
   // Shared tasks
   // --------------------------------------------------------------------
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One register access: a write of d when we is high, else a read of d.
   // Each channel is held until its own ready, so the slave's order is free.
   task automatic acc(input logic we, input logic [9:0] idx,
                      input logic [7:0] d, input logic [1:0] er);
      int n;
      logic ad, wd, rd;
      n = 0;
      ad = 1'b0;
      wd = !we;
      rd = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_araddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= we;
      s_axi_wvalid <= we;
      s_axi_bready <= we;
      s_axi_arvalid <= !we;
      s_axi_rready <= !we;
      while (!rd && n < 50) begin
         @(posedge aclk);
         n++;
         if (!ad && (we ? s_axi_awready : s_axi_arready)) begin
            s_axi_awvalid <= 1'b0;
            s_axi_arvalid <= 1'b0;
            ad = 1'b1;
         end
         if (!wd && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            wd = 1'b1;
         end
         if (we ? s_axi_bvalid : s_axi_rvalid) begin
            s_axi_bready <= 1'b0;
            s_axi_rready <= 1'b0;
            rd = 1'b1;
            chk({30'h0, we ? s_axi_bresp : s_axi_rresp}, {30'h0, er});
            if (!we) chk(s_axi_rdata, {24'h000000, d});
         end
      end
      if (!rd) begin
         n_fail++;
         report_and_stop();
      end
   endtask

   // Counts the cycles each pin is high over a window of n cycles.
   task automatic meas(input int n, output int a, output int b);
      a = 0;
      b = 0;
      repeat (n) begin
         @(posedge aclk);
         if (cmp_a_out_pin === 1'b1) a++;
         if (cmp_b_out_pin === 1'b1) b++;
      end
   endtask

   // --------------------------------------------------------------------
   // Test sequence
   // --------------------------------------------------------------------
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      acc(1'b0, i_ca, 8'h00, ok);
      acc(1'b0, i_cb, 8'h00, ok);
      chk({29'h0, cmp_a_override, cmp_b_override, irq}, 32'h0);
      acc(1'b1, i_ca, 8'hff, ok);
      acc(1'b0, i_ca, 8'hf3, ok);
      // Pin direction sits outside; only ownership is visible here.
      chk({30'h0, cmp_a_override, cmp_b_override}, 32'h3);
      acc(1'b1, i_cb, 8'hf0, ok);
      acc(1'b0, i_cb, 8'h00, ok);
      acc(1'b1, 10'h0a0, 8'h5a, `TW_RESP_SLVERR);
      acc(1'b0, 10'h0a0, 8'h00, `TW_RESP_SLVERR);
      $display("test registers done");
      // Clear-on-match with top at compare A: toggle every top+1 cycles.
      acc(1'b1, i_pa, 8'h03, ok);
      acc(1'b1, i_ca, 8'h52, ok);
      acc(1'b1, i_cb, 8'h01, ok);
      chk({30'h0, cmp_a_override, cmp_b_override}, 32'h3);
      repeat (8) @(posedge aclk);
      ta = cmp_a_out_pin;
      tb = cmp_b_out_pin;
      repeat (4) @(posedge aclk);
      chk({30'h0, cmp_a_out_pin, cmp_b_out_pin}, {30'h0, ~ta, ~tb});
      for (int k = 2; k < 4; k++) begin
         acc(1'b1, i_ca, {k[1:0], k[1:0], 4'h2}, ok);
         repeat (8) @(posedge aclk);
         chk({30'h0, cmp_a_out_pin, cmp_b_out_pin},
             {30'h0, k[0], k[0]});
      end
      $display("test non-pwm done");
      // Fast mode 7; the long settle lets a write land at bottom first.
      acc(1'b1, i_pb, 8'h03, ok);
      acc(1'b1, i_pa, 8'h09, ok);
      acc(1'b1, i_cb, 8'h09, ok);
      for (int k = 2; k < 4; k++) begin
         acc(1'b1, i_ca, {k[1:0], k[1:0], 4'h3}, ok);
         chk({31'h0, cmp_a_override}, 32'h1);
         repeat (30) @(posedge aclk);
         meas(10, ha, hb);
         chk(ha, k == 2 ? 10 : 0);
         chk(hb, k == 2 ? 4 : 6);
      end
      acc(1'b1, i_pb, 8'h09, ok);
      repeat (30) @(posedge aclk);
      meas(10, ha, hb);
      chk(hb, 0);
      acc(1'b1, i_ca, 8'h53, ok);
      chk({30'h0, cmp_a_override, cmp_b_override}, 32'h2);
      acc(1'b1, i_cb, 8'h01, ok);
      chk({30'h0, cmp_a_override, cmp_b_override}, 32'h0);
      // Fast mode 3: a non-inverted pulse runs from bottom up to the match.
      acc(1'b1, i_ca, 8'h83, ok);
      repeat (300) @(posedge aclk);
      meas(256, ha, hb);
      chk(ha, 10);
      $display("test fast pwm done");
      // Phase mode 5 with compare A at top holds channel A high.
      acc(1'b1, i_pb, 8'h03, ok);
      acc(1'b1, i_cb, 8'h09, ok);
      for (int k = 2; k < 4; k++) begin
         acc(1'b1, i_ca, {2'h2, k[1:0], 4'h1}, ok);
         repeat (300) @(posedge aclk);
         meas(18, ha, hb);
         chk(ha, 18);
         chk(hb, k == 2 ? 6 : 12);
      end
      acc(1'b1, i_pa, 8'h10, ok);
      acc(1'b1, i_cb, 8'h01, ok);
      acc(1'b1, i_ca, 8'h81, ok);
      repeat (600) @(posedge aclk);
      meas(510, ha, hb);
      chk(ha, 32);
      $display("test phase pwm done");
      // Flags stay set once stopped; the enable masks the line.
      acc(1'b1, i_cb, 8'h00, ok);
      acc(1'b0, i_st, 8'h07, ok);
      acc(1'b1, i_en, 8'h01, ok);
      chk({31'h0, irq}, 32'h1);
      acc(1'b1, i_en, 8'h00, ok);
      chk({31'h0, irq}, 32'h0);
      acc(1'b1, i_cl, 8'h07, ok);
      acc(1'b0, i_st, 8'h00, ok);
      acc(1'b0, i_cl, 8'h00, ok);
      acc(1'b1, i_en, 8'h07, ok);
      acc(1'b0, i_en, 8'h07, ok);
      chk({31'h0, irq}, 32'h0);
      $display("test interrupt done");
      report_and_stop();
   end
endmodule
`default_nettype wire
